/* hdl/tpm_defines.vh */
// Purpose: Constants for the test port mode select block.
// Assumes: Included by hdl/tpm_mode_select.v only.
// Notes: Fuse level 1 means blown.
`ifndef TPM_DEFINES_VH
`define TPM_DEFINES_VH
`define TPM_FUSE_BLOWN 1'h1
`define TPM_MODE_FLEX 1'h0
`define TPM_MODE_DED 1'h1
`define TPM_TCK_SYNC_RST 3'h0
`define TPM_PIN_SYNC_RST 3'h7
`define TPM_ST_RESET 4'hf
`define TPM_ST_IDLE 4'hc
`define TPM_ST_SEL_DR 4'h7
`define TPM_ST_CAP_DR 4'h6
`define TPM_ST_SH_DR 4'h2
`define TPM_ST_EX1_DR 4'h1
`define TPM_ST_PA_DR 4'h3
`define TPM_ST_EX2_DR 4'h0
`define TPM_ST_UP_DR 4'h5
`define TPM_ST_SEL_IR 4'h4
`define TPM_ST_CAP_IR 4'he
`define TPM_ST_SH_IR 4'ha
`define TPM_ST_EX1_IR 4'h9
`define TPM_ST_PA_IR 4'hb
`define TPM_ST_EX2_IR 4'h8
`define TPM_ST_UP_IR 4'hd
`endif

/* hdl/tpm_mode_select.v */
// Purpose: Chooses dedicated or flexible use of the test port pins and
//          tracks the test access port state from the sampled test clock.
// Assumes: clk_i at 20 MHz, test clock much slower (400 ns in the bench).
// Notes: Pins are split into input, output and output enable.
//        The fuse is read once after reset; a new level needs a reset.
//        Test clock high and low phases must each last two clk_i
//        periods or more, or an edge is lost in the synchroniser.
//
// Overview of operation
// - Fuse blown selects dedicated, else flexible mode
// - Unprogrammed fuse powers up in flexible mode
// - Dedicated mode reserves TCK, TDI, TDO for scan
// - Flexible mode lets TCK, TDI, TDO be user I/O
// - Flexible: low TMS hands pins to scan
// - Dedicated mode enables pull-ups on TMS, TDI
// - Dedicated mode: TMS drives standard state machine
`timescale 1ns/1ns
`include "tpm_defines.vh"

module tpm_mode_select (
   input wire clk_i,           // System clock, 20 MHz.
   input wire rstn_i,          // Asynchronous reset, active low.
   input wire fuse_i,          // Mode fuse level, 1 when blown.
   input wire tck_i,           // Test clock pin level.
   input wire tms_i,           // Test mode select pin level.
   input wire tdi_i,           // Test data in pin level.
   input wire user_tdo_i,      // User data for the data-out pin.
   input wire user_tdo_oe_i,   // User drive enable for the data-out pin.
   input wire scan_tdo_i,      // Scan chain serial output.
   output reg mode_ded_o,      // High in dedicated test mode.
   output reg scan_active_o,   // High while pins belong to scan.
   output reg tms_pullup_o,    // Internal pull-up enable on TMS.
   output reg tdi_pullup_o,    // Internal pull-up enable on TDI.
   output reg tdo_o,           // Data-out pin level.
   output reg tdo_oe_o,        // Data-out pin drive enable.
   output reg user_tck_o,      // Test clock pin value offered to user.
   output reg user_tdi_o,      // Data-in pin value offered to user.
   output reg user_pins_ok_o,  // High while user may use the pins.
   output reg tck_rise_o,      // One-cycle pulse on test clock rise while scan_q is set.
   output reg tdi_smp_o,       // Data-in sampled on test clock rise.
   output reg [3:0] tap_state_o // Test access port state.
);

   // Two stages of each pin shift register synchronise, the third one
   // holds the previous level for edge detection.
   reg [2:0] tck_s_q, tms_s_q, tdi_s_q;
   reg fuse_s1_q, fuse_s2_q;
   reg mode_q, mode_vld_q;
   reg [3:0] st_q;
   reg [3:0] st_d;
   reg scan_q;
   wire tck_r, tck_f, tms_s, tdi_s;
   wire user_own;

   assign tck_r = tck_s_q[1] & ~tck_s_q[2];
   assign tck_f = ~tck_s_q[1] & tck_s_q[2];
   assign tms_s = tms_s_q[1];
   assign tdi_s = tdi_s_q[1];

   // Standard next-state table of the test access port.
   function [3:0] tap_next;
      input [3:0] st;
      input tms;
      begin
         case (st)
            `TPM_ST_RESET: tap_next = tms ? `TPM_ST_RESET : `TPM_ST_IDLE;
            `TPM_ST_IDLE: tap_next = tms ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
            `TPM_ST_SEL_DR: tap_next = tms ? `TPM_ST_SEL_IR : `TPM_ST_CAP_DR;
            `TPM_ST_CAP_DR: tap_next = tms ? `TPM_ST_EX1_DR : `TPM_ST_SH_DR;
            `TPM_ST_SH_DR: tap_next = tms ? `TPM_ST_EX1_DR : `TPM_ST_SH_DR;
            `TPM_ST_EX1_DR: tap_next = tms ? `TPM_ST_UP_DR : `TPM_ST_PA_DR;
            `TPM_ST_PA_DR: tap_next = tms ? `TPM_ST_EX2_DR : `TPM_ST_PA_DR;
            `TPM_ST_EX2_DR: tap_next = tms ? `TPM_ST_UP_DR : `TPM_ST_SH_DR;
            `TPM_ST_UP_DR: tap_next = tms ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
            `TPM_ST_SEL_IR: tap_next = tms ? `TPM_ST_RESET : `TPM_ST_CAP_IR;
            `TPM_ST_CAP_IR: tap_next = tms ? `TPM_ST_EX1_IR : `TPM_ST_SH_IR;
            `TPM_ST_SH_IR: tap_next = tms ? `TPM_ST_EX1_IR : `TPM_ST_SH_IR;
            `TPM_ST_EX1_IR: tap_next = tms ? `TPM_ST_UP_IR : `TPM_ST_PA_IR;
            `TPM_ST_PA_IR: tap_next = tms ? `TPM_ST_EX2_IR : `TPM_ST_PA_IR;
            `TPM_ST_EX2_IR: tap_next = tms ? `TPM_ST_UP_IR : `TPM_ST_SH_IR;
            `TPM_ST_UP_IR: tap_next = tms ? `TPM_ST_SEL_DR : `TPM_ST_IDLE;
            default: tap_next = `TPM_ST_RESET;
         endcase
      end
   endfunction

   // User logic may own the shared pins only once the mode is latched,
   // the mode is flexible and no scan sequence has claimed them.
   function user_owns;
      input vld;
      input mode;
      input scan;
      begin
         user_owns = vld && (mode == `TPM_MODE_FLEX) && !scan;
      end
   endfunction

   assign user_own = user_owns(mode_vld_q, mode_q, scan_q);

   // Pins arrive from outside the clock domain; bit 0 is read only by bit 1.
   // TMS and TDI restart at their pulled-up level and TCK at its idle low
   // level, so leaving reset never shows a false edge or a false TMS low.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tck_s_q <= `TPM_TCK_SYNC_RST;
         tms_s_q <= `TPM_PIN_SYNC_RST;
         tdi_s_q <= `TPM_PIN_SYNC_RST;
      end else begin
         tck_s_q <= {tck_s_q[1:0], tck_i};
         tms_s_q <= {tms_s_q[1:0], tms_i};
         tdi_s_q <= {tdi_s_q[1:0], tdi_i};
      end
   end

   // The fuse pair has no reset on purpose: it keeps following the fuse
   // while reset is held, so the level is settled at the first edge after
   // release. A reset pair would hand the mode latch a forced zero there
   // and dedicated mode could never be chosen.
   always @(posedge clk_i) begin
      fuse_s1_q <= fuse_i;
      fuse_s2_q <= fuse_s1_q;
   end

   // The fuse is caught once after reset; a fuse cannot change in use,
   // and latching it keeps a glitch from flipping pin ownership.
   // The latch closes on the first edge after reset is released.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_q <= `TPM_MODE_FLEX;
         mode_vld_q <= 1'h0;
      end else if (!mode_vld_q) begin
         mode_q <= (fuse_s2_q == `TPM_FUSE_BLOWN) ? `TPM_MODE_DED
                                                   : `TPM_MODE_FLEX;
         mode_vld_q <= 1'h1;
      end
   end

   // Flexible mode: scan starts when TMS is seen low and ends when the
   // state machine walks back to reset with TMS high.
   // Holding the reset state while idle means a stray test clock in user
   // mode can never walk the state machine.
   always @(*) begin
      st_d = st_q;
      if (mode_q == `TPM_MODE_DED) begin
         if (tck_r)
            st_d = tap_next(st_q, tms_s);
      end else if (!scan_q) begin
         st_d = `TPM_ST_RESET;
      end else if (tck_r) begin
         st_d = tap_next(st_q, tms_s);
      end
   end

   // A TMS low seen in the cycle of the closing test clock rise keeps the
   // scan claim: a start request is never lost to a finishing sequence.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= `TPM_ST_RESET;
         scan_q <= 1'h0;
      end else begin
         st_q <= st_d;
         if (mode_q == `TPM_MODE_DED)
            scan_q <= 1'h1;
         else if (!tms_s)
            scan_q <= 1'h1;
         else if (st_d == `TPM_ST_RESET && tck_r)
            scan_q <= 1'h0;
      end
   end

   // Status outputs are plain registered copies, so no output of this
   // block ever carries a combinational glitch. The cost is one cycle of
   // extra latency, which is small against the test clock period.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         mode_ded_o <= 1'h0;
         scan_active_o <= 1'h0;
         tms_pullup_o <= 1'h0;
         tdi_pullup_o <= 1'h0;
         tck_rise_o <= 1'h0;
         tdi_smp_o <= 1'h0;
         tap_state_o <= `TPM_ST_RESET;
      end else begin
         mode_ded_o <= mode_q;
         scan_active_o <= scan_q;
         tms_pullup_o <= mode_q;
         tdi_pullup_o <= mode_q;
         tck_rise_o <= tck_r & scan_q;
         if (tck_r)
            tdi_smp_o <= tdi_s;
         tap_state_o <= st_q;
      end
   end

   // Pin ownership. Until the mode is latched nothing is handed to user
   // logic, so a dedicated part never shows user data on its test pins,
   // not even in the cycle in which the mode first becomes known.
   always @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tdo_o <= 1'h0;
         tdo_oe_o <= 1'h0;
         user_tck_o <= 1'h0;
         user_tdi_o <= 1'h0;
         user_pins_ok_o <= 1'h0;
      end else begin
         user_pins_ok_o <= user_own;
         user_tck_o <= user_own ? tck_s_q[1] : 1'h0;
         user_tdi_o <= user_own ? tdi_s : 1'h0;
         if (!user_own) begin
            // Data-out changes on the falling test clock; from the first fall after a
            // scan claim it is driven only in the two shift states, so a controller
            // that samples on the rising test clock always sees settled data.
            if (tck_f) begin
               tdo_o <= scan_tdo_i;
               tdo_oe_o <= (st_q == `TPM_ST_SH_DR) ||
                           (st_q == `TPM_ST_SH_IR);
            end
         end else begin
            tdo_o <= user_tdo_i;
            tdo_oe_o <= user_tdo_oe_i;
         end
      end
   end

endmodule // tpm_mode_select

/* tb/tpm_mode_select_chk.sv */
// Purpose: Port-level assertions for the test port mode select block.
// Assumes: The fuse level stays steady while reset is released.
// Notes: A small counter masks the fuse latch just after reset.
`timescale 1ns/1ns
module tpm_mode_select_chk (
   input wire clk_i, // System clock.
   input wire rstn_i, // Reset, active low.
   input wire fuse_i, // Mode fuse.
   input wire tms_i, // Mode select pin.
   input wire mode_ded_o, // Dedicated mode.
   input wire scan_active_o, // Scan owns pins.
   input wire tms_pullup_o, // TMS pull-up.
   input wire tdi_pullup_o, // TDI pull-up.
   input wire user_tck_o, // Clock to user.
   input wire user_tdi_o, // Data to user.
   input wire user_pins_ok_o, // User owns pins.
   input wire [3:0] tap_state_o // State code.
);
   logic [2:0] cnt_q;
   always @(posedge clk_i or negedge rstn_i)
      if (!rstn_i)
         cnt_q <= 3'h0;
      else if (cnt_q != 3'h4)
         cnt_q <= cnt_q + 3'h1;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_fuse_mode: assert property (cnt_q == 3'h4 |-> mode_ded_o == fuse_i)
      else $error("mode differs from fuse");
   a_flex_default: assert property (cnt_q == 3'h4 && !fuse_i |->
      !mode_ded_o && !tms_pullup_o) else $error("not flexible");
   a_ded_reserve: assert property (mode_ded_o |->
      !user_pins_ok_o && !user_tck_o && !user_tdi_o) else $error("pins leak");
   a_flex_user: assert property ((cnt_q == 3'h4 && !mode_ded_o
      && !scan_active_o)[*2] |-> user_pins_ok_o) else $error("user lost");
   a_tms_scan: assert property ((cnt_q == 3'h4 && !mode_ded_o
      && !tms_i)[*5] |=> scan_active_o) else $error("scan not taken");
   a_pull_ups: assert property (cnt_q == 3'h4 |->
      tms_pullup_o == mode_ded_o && tdi_pullup_o == mode_ded_o)
      else $error("pull-up wrong");
   a_rst_idle: assert property ($past(tap_state_o) == 4'hf
      && tap_state_o != 4'hf |-> tap_state_o == 4'hc) else $error("bad exit");
   a_flex_tap_rst: assert property ((!mode_ded_o && !scan_active_o)[*3]
      |-> tap_state_o == 4'hf) else $error("state not held");
   cover property (scan_active_o && !mode_ded_o);
   cover property (tap_state_o == 4'h2);
   cover property (mode_ded_o && tap_state_o == 4'hc);
endmodule // tpm_mode_select_chk
bind tpm_mode_select tpm_mode_select_chk i_chk (.clk_i, .rstn_i, .fuse_i,
   .tms_i, .mode_ded_o, .scan_active_o, .tms_pullup_o, .tdi_pullup_o,
   .user_tck_o, .user_tdi_o, .user_pins_ok_o, .tap_state_o);

/* tb/tpm_tester.sv */
// Purpose: Behavioural boundary scan controller on the far side.
// Assumes: Called from the bench at falling system clock edges.
// Notes: The test clock stands low between frames.
`timescale 1ns/1ns
module tpm_tester (
   input wire logic clk_i, // System clock.
   output logic tck_o, // Test clock.
   output logic tms_o, // Mode select.
   output logic tdi_o // Serial data in.
);
   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end
   // One 400 ns test clock period. TMS moves right after the fall and TDI
   // half way through the low phase, so each pin changes once per bit.
   task automatic bit_t(input logic m, input logic d);
      tms_o = m;
      repeat (2) @(negedge clk_i);
      tdi_o = d;
      repeat (2) @(negedge clk_i);
      tck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      tck_o = 1'b0;
   endtask
endmodule // tpm_tester

/* tb/tpm_mode_select_test.sv */
// Purpose: Self-checking bench for the test port mode select block.
// Assumes: 20 MHz system clock; the tester model drives the test pins.
// Notes: Rows cover both fuse levels; scan walks follow by hand.
`timescale 1ns/1ns
module tpm_mode_select_test;
   logic clk_i = 1'b0, rstn_i = 1'b0, fuse_i = 1'b0;
   logic user_tdo_i = 1'b0, user_tdo_oe_i = 1'b1, scan_tdo_i = 1'b1;
   wire tck_i, tms_i, tdi_i, mode_ded_o, scan_active_o, tms_pullup_o;
   wire tdi_pullup_o, tdo_o, tdo_oe_o, user_tck_o, user_tdi_o;
   wire user_pins_ok_o, tck_rise_o, tdi_smp_o;
   wire [3:0] tap_state_o;
   wire [3:0] mode_vec = {mode_ded_o, tms_pullup_o, tdi_pullup_o,
      user_pins_ok_o};
   wire [7:0] view = {scan_active_o, user_pins_ok_o, tdo_oe_o, tdo_o,
      tap_state_o};
   logic [4:0] rows [2] = '{5'h01, 5'h1e};
   int err_total = 0, checks_done = 0;
   int rises = 0;
   always #25 clk_i = ~clk_i;
   // The rise pulse stands for one cycle, so each one is seen once here.
   always @(negedge clk_i)
      if (tck_rise_o === 1'b1)
         rises++;
   tpm_tester i_tpm_tester (.clk_i, .tck_o(tck_i), .tms_o(tms_i),
      .tdi_o(tdi_i));
   tpm_mode_select i_tpm_mode_select (.clk_i, .rstn_i, .fuse_i, .tck_i,
      .tms_i, .tdi_i, .user_tdo_i, .user_tdo_oe_i, .scan_tdo_i, .mode_ded_o,
      .scan_active_o, .tms_pullup_o, .tdi_pullup_o, .tdo_o, .tdo_oe_o,
      .user_tck_o, .user_tdi_o, .user_pins_ok_o, .tck_rise_o, .tdi_smp_o,
      .tap_state_o);
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic boot(input logic f);
      rstn_i = 1'b0;
      fuse_i = f;
      repeat (8) @(negedge clk_i);
      rstn_i = 1'b1;
      repeat (5) @(negedge clk_i);
   endtask
   // The wait after the frame covers pin sync and state latency.
   task automatic walk(input logic [4:0] m, input int n);
      for (int i = 0; i < n; i++)
         i_tpm_tester.bit_t(m[i], i[0]);
      repeat (6) @(negedge clk_i);
   endtask
   initial begin
      for (int r = 0; r < 2; r++) begin
         boot(rows[r][4]);
         chk(mode_vec, rows[r][3:0]);
      end
      boot(1'b0);
      walk(5'b00011, 2);
      chk(view, 8'h6f);
      chk({user_tck_o, user_tdi_o}, 8'h01);
      i_tpm_tester.tms_o = 1'b0;
      for (int k = 0; k < 20 && scan_active_o !== 1'b1; k++)
         @(negedge clk_i);
      chk(scan_active_o, 1'b1);
      if (scan_active_o !== 1'b1)
         summarize();
      walk(5'b00010, 4);
      chk(view, 8'hb2);
      chk(rises[7:0], 8'h04);
      chk({tdi_smp_o, user_tdi_o}, 8'h02);
      walk(5'b11111, 5);
      chk(view, 8'h6f);
      boot(1'b1);
      walk(5'b00010, 4);
      chk(view & 8'h7f, 8'h32);
      chk(rises[7:0], 8'h0d);
      walk(5'b11111, 5);
      chk(view & 8'h6f, 8'h0f);
      summarize();
   end
endmodule // tpm_mode_select_test
